/* logic/port_pin_params.svh */
// offsets, field positions, reset values and widths of the port pin block
// How it works
// - clamp inputs in power-down, standby, noise-reduction sleep
// - external interrupt pins escape the sleep clamp
// - clamp release edge sets interrupt flag
// - pull-ups are off during reset
// - inputs enabled in reset, active and idle
// - no override: pull-up when dir,out,off = 010
// - pull-up override enable selects override value
// - no override: driver enable from direction bit
// - direction override enable selects override value
// - driven level from override or output bit
// - out-level override forces the driven level
// - no override: input gate follows processor state
// - input gate override forces gate value
// - raw gated input tapped before the synchronizer
// - strobes and pull-up off per port, clamp shared
// - analog path bypasses the digital buffers
// - direction 1 output; out bit on input pulls up
// - read-back bit passes a synchronizer
// - pins go high impedance at reset, clockless
`ifndef PORT_PIN_PARAMS_SVH
`define PORT_PIN_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_DIRECTION  12'h000
`define OFS_OUT_VALUE  12'h004
`define OFS_PIN_INPUT  12'h008
`define OFS_CONTROL    12'h00C
`define OFS_INT_ENABLE 12'h010
`define OFS_INT_SENSE  12'h014
`define OFS_INT_FLAG   12'h018

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTRL_PULLUP_OFF_BIT 0
`define RST_DIRECTION       8'h00
`define RST_OUT_VALUE       8'h00
`define RST_SENSE           16'h0000
`define PIN_COUNT           8

`endif

/* logic/port_pin_pkg.sv */
// types shared by the port pin override mux
package port_pin_pkg;

    // ************************************************************
    // processor state as seen from the sleep controller
    // ************************************************************
    typedef enum logic [2:0] {
        MODE_ACTIVE     = 3'b000,
        MODE_IDLE       = 3'b001,
        MODE_ADC_QUIET  = 3'b010,
        MODE_POWER_DOWN = 3'b011,
        MODE_STANDBY    = 3'b100
    } sleep_mode_t;

    // per-pin interrupt sense, two bits per pin
    typedef enum logic [1:0] {
        SENSE_LOW     = 2'b00,
        SENSE_ANY     = 2'b01,
        SENSE_FALLING = 2'b10,
        SENSE_RISING  = 2'b11
    } sense_t;

    // override pairs from the alternate-function peripherals, one bit per pin
    typedef struct packed {
        logic [7:0] pullup_override_enable;
        logic [7:0] pullup_override_value;
        logic [7:0] direction_override_enable;
        logic [7:0] direction_override_value;
        logic [7:0] out_level_override_enable;
        logic [7:0] out_level_override_value;
        logic [7:0] input_gate_override_enable;
        logic [7:0] input_gate_override_value;
    } pin_override_t;

    // pad-facing drive, one bit per pin
    typedef struct packed {
        logic [7:0] drive_level;
        logic [7:0] drive_enable;
        logic [7:0] pullup_enable;
    } pad_drive_t;

endpackage : port_pin_pkg

/* logic/port_pin_override_mux.sv */
// one 8-pin I/O port: registers, override muxing, input gating, pin events
`timescale 1ns/1ps
`include "port_pin_params.svh"

module port_pin_override_mux (
    // clock, reset, clock enable
    input  wire logic                         sys_clk_in,
    input  wire logic                         rst_n_in,
    input  wire logic                         ce_in,
    // apb slave
    input  wire logic                         psel_in,
    input  wire logic                         penable_in,
    input  wire logic                         pwrite_in,
    input  wire logic [11:0]                  paddr_in,
    input  wire logic [31:0]                  pwdata_in,
    output logic                              pready_out,
    output logic                              pslverr_out,
    output logic [31:0]                       prdata_out,
    // sleep controller, shared by all ports
    input  wire port_pin_pkg::sleep_mode_t    sleep_mode_in,
    // alternate-function peripherals
    input  wire port_pin_pkg::pin_override_t  overrides_in,
    output logic [7:0]                        alt_function_input_tap_out,
    // pads
    input  wire logic [7:0]                   pad_in,
    output port_pin_pkg::pad_drive_t          pad_out
);

    // ************************************************************
    // local signals
    // ************************************************************
    logic [7:0]  pin_direction_bit_q;
    logic [7:0]  pin_output_value_bit_q;
    logic        global_pullup_off_q;
    logic [7:0]  int_enable_q;
    logic [15:0] int_sense_q;
    logic [7:0]  int_flag_q;
    logic [7:0]  int_flag_d;
    logic [7:0]  sync1_q;
    logic [7:0]  sync2_q;
    logic [7:0]  sync3_q;
    logic [7:0]  pin_sampled_input_bit_q;
    logic [7:0]  prev_input_q;
    logic [7:0]  pin_event;
    logic [7:0]  input_gate;
    logic [7:0]  gated_pad;
    logic        clamp;
    logic        setup_phase;
    logic        access_done;
    logic        port_value_write_strobe;
    logic        port_direction_write_strobe;
    logic        port_pin_read_strobe;
    logic        ctrl_write;
    logic        ien_write;
    logic        sense_write;
    logic        flag_write;
    logic        addr_known;
    logic [31:0] read_word;
    port_pin_pkg::pad_drive_t pad_d;

    // ************************************************************
    // helpers
    // ************************************************************

    // per-pin override mux: enable picks override value over base
    function automatic logic [7:0] override_mux(input logic [7:0] oe,
                                                input logic [7:0] ov,
                                                input logic [7:0] base);
        override_mux = (oe & ov) | (~oe & base);
    endfunction : override_mux

    // address compare against one register offset
    function automatic logic hit(input logic [11:0] addr, input logic [11:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    // ************************************************************
    // apb decode
    // ************************************************************

    // zero-wait slave: setup computes the answer, access completes it
    assign setup_phase = psel_in & ~penable_in;
    assign access_done = psel_in & penable_in & pready_out & ~pslverr_out;

    // port-wide strobes, one set for all eight pins
    assign port_value_write_strobe     = access_done & pwrite_in &
                                         hit(paddr_in, `OFS_OUT_VALUE);
    assign port_direction_write_strobe = access_done & pwrite_in &
                                         hit(paddr_in, `OFS_DIRECTION);
    assign port_pin_read_strobe        = setup_phase & ~pwrite_in &
                                         hit(paddr_in, `OFS_PIN_INPUT);
    assign ctrl_write  = access_done & pwrite_in & hit(paddr_in, `OFS_CONTROL);
    assign ien_write   = access_done & pwrite_in & hit(paddr_in, `OFS_INT_ENABLE);
    assign sense_write = access_done & pwrite_in & hit(paddr_in, `OFS_INT_SENSE);
    assign flag_write  = access_done & pwrite_in & hit(paddr_in, `OFS_INT_FLAG);

    // read mux; the pin input register is read-only, writes to it are dropped
    always_comb begin
        addr_known = 1'b1;
        read_word  = 32'h0000_0000;
        case (paddr_in)
            `OFS_DIRECTION:  read_word[7:0]  = pin_direction_bit_q;
            `OFS_OUT_VALUE:  read_word[7:0]  = pin_output_value_bit_q;
            `OFS_PIN_INPUT:  read_word[7:0]  = port_pin_read_strobe ?
                                               pin_sampled_input_bit_q : 8'h00;
            `OFS_CONTROL:    read_word[`CTRL_PULLUP_OFF_BIT] = global_pullup_off_q;
            `OFS_INT_ENABLE: read_word[7:0]  = int_enable_q;
            `OFS_INT_SENSE:  read_word[15:0] = int_sense_q;
            `OFS_INT_FLAG:   read_word[7:0]  = int_flag_q;
            default:         addr_known      = 1'b0;
        endcase
    end

    // answer registered at setup so pready, pslverr, prdata are flops
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else if (ce_in) begin
            pready_out  <= setup_phase;
            pslverr_out <= setup_phase & ~addr_known;
            prdata_out  <= (setup_phase & ~pwrite_in) ? read_word : 32'h0000_0000;
        end
    end

    // ************************************************************
    // software pin settings
    // ************************************************************

    // direction and output value, written by the port strobes
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_direction_bit_q    <= `RST_DIRECTION;
            pin_output_value_bit_q <= `RST_OUT_VALUE;
        end else if (ce_in) begin
            if (port_direction_write_strobe) begin
                pin_direction_bit_q <= pwdata_in[7:0];
            end
            if (port_value_write_strobe) begin
                pin_output_value_bit_q <= pwdata_in[7:0];
            end
        end
    end

    // global pull-up off, one bit for all eight pins of this port
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            global_pullup_off_q <= 1'b0;
        end else if (ce_in && ctrl_write) begin
            global_pullup_off_q <= pwdata_in[`CTRL_PULLUP_OFF_BIT];
        end
    end

    // ************************************************************
    // pad drive
    // ************************************************************

    // overrides come straight from the peripherals that own each pin
    always_comb begin
        pad_d.drive_enable = override_mux(overrides_in.direction_override_enable,
                                          overrides_in.direction_override_value,
                                          pin_direction_bit_q);
        pad_d.drive_level  = override_mux(overrides_in.out_level_override_enable,
                                          overrides_in.out_level_override_value,
                                          pin_output_value_bit_q);
        pad_d.pullup_enable = override_mux(overrides_in.pullup_override_enable,
                                           overrides_in.pullup_override_value,
                                           ~pin_direction_bit_q & pin_output_value_bit_q
                                           & {8{~global_pullup_off_q}});
    end

    // registered pad drive; async reset tri-states pins and drops pull-ups
    // without waiting for a clock edge
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pad_out <= '0;
        end else if (ce_in) begin
            pad_out <= pad_d;
        end
    end
    // the analog line meets the pad in the pad ring, never through these flops

    // ************************************************************
    // input gating
    // ************************************************************

    // deep sleep modes clamp; reset, active and idle keep inputs alive
    always_comb begin
        case (sleep_mode_in)
            port_pin_pkg::MODE_ADC_QUIET:  clamp = 1'b1;
            port_pin_pkg::MODE_POWER_DOWN: clamp = 1'b1;
            port_pin_pkg::MODE_STANDBY:    clamp = 1'b1;
            default:                       clamp = 1'b0;
        endcase
    end

    // enabled interrupt pins must still see wake-up edges while clamped
    assign input_gate = override_mux(overrides_in.input_gate_override_enable,
                                     overrides_in.input_gate_override_value,
                                     {8{~clamp}} | int_enable_q);
    assign gated_pad  = pad_in & input_gate;

    // raw tap for peripherals, one flop only so they add their own sync
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            alt_function_input_tap_out <= 8'h00;
        end else if (ce_in) begin
            alt_function_input_tap_out <= gated_pad;
        end
    end

    // ************************************************************
    // read-back synchronizer
    // ************************************************************

    // three stages; a new level counts once stages two and three agree,
    // trading one cycle of latency for immunity to a metastable settle
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            sync3_q <= 8'h00;
        end else if (ce_in) begin
            sync1_q <= gated_pad;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // accepted pin level
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_sampled_input_bit_q <= 8'h00;
        end else if (ce_in) begin
            for (int i = 0; i < `PIN_COUNT; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    pin_sampled_input_bit_q[i] <= sync3_q[i];
                end
            end
        end
    end

    // ************************************************************
    // pin events
    // ************************************************************

    // interrupt configuration
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_enable_q <= 8'h00;
            int_sense_q  <= `RST_SENSE;
        end else if (ce_in) begin
            if (ien_write) begin
                int_enable_q <= pwdata_in[7:0];
            end
            if (sense_write) begin
                int_sense_q <= pwdata_in[15:0];
            end
        end
    end

    // edge or low-level detect on the accepted level; the flag sets even while the
    // interrupt is disabled, so a clamp release on a high pin leaves a flag
    always_comb begin
        for (int i = 0; i < `PIN_COUNT; i++) begin
            case (port_pin_pkg::sense_t'(int_sense_q[2*i +: 2]))
                port_pin_pkg::SENSE_LOW:     pin_event[i] = ~pin_sampled_input_bit_q[i];
                port_pin_pkg::SENSE_ANY:     pin_event[i] = pin_sampled_input_bit_q[i]
                                                            ^ prev_input_q[i];
                port_pin_pkg::SENSE_FALLING: pin_event[i] = prev_input_q[i]
                                                            & ~pin_sampled_input_bit_q[i];
                port_pin_pkg::SENSE_RISING:  pin_event[i] = ~prev_input_q[i]
                                                            & pin_sampled_input_bit_q[i];
                default:                     pin_event[i] = 1'b0;
            endcase
        end
    end

    // write one to clear; a same-cycle event wins over the clear
    assign int_flag_d = (int_flag_q & ~(flag_write ? pwdata_in[7:0] : 8'h00)) | pin_event;

    // previous level and sticky flags
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prev_input_q <= 8'h00;
            int_flag_q   <= 8'h00;
        end else if (ce_in) begin
            prev_input_q <= pin_sampled_input_bit_q;
            int_flag_q   <= int_flag_d;
        end
    end

endmodule : port_pin_override_mux

/* dv/pad_world.sv */
// pad and alternate-function peripheral model facing the port pin block
`timescale 1ns/1ps

module pad_world (
    // clock
    input  wire logic                        clk_in,
    // device side
    input  wire port_pin_pkg::pad_drive_t    drive_in,
    output port_pin_pkg::pin_override_t      overrides_out,
    output logic [7:0]                       level_out,
    // bench side
    input  wire port_pin_pkg::pin_override_t cfg_in,
    input  wire logic [7:0]                  ext_level_in,
    input  wire logic [7:0]                  ext_drive_in
);
    // ********
    // pad resolution
    // ********
    logic [7:0] float_q = 8'h55;

    // an undriven pad flips every cycle, so no check can lean on it
    always_ff @(posedge clk_in) float_q <= ~float_q;

    // each peripheral hands over its own enable/value pairs
    assign overrides_out = cfg_in;

    // device drive first, then an outside source, then the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (drive_in.drive_enable[i]) level_out[i] = drive_in.drive_level[i];
            else if (ext_drive_in[i]) level_out[i] = ext_level_in[i];
            else if (drive_in.pullup_enable[i]) level_out[i] = 1'b1;
            else level_out[i] = float_q[i];
        end
    end
endmodule : pad_world

/* dv/port_pin_override_mux_chk.sv */
// port-level checker for the port pin override mux
`timescale 1ns/1ps
`include "port_pin_params.svh"

module port_pin_chk (
    // clock and reset
    input wire logic                        sys_clk_in,
    input wire logic                        rst_n_in,
    input wire logic                        ce_in,
    // apb
    input wire logic                        psel_in,
    input wire logic                        penable_in,
    input wire logic                        pwrite_in,
    input wire logic [11:0]                 paddr_in,
    input wire logic [31:0]                 pwdata_in,
    input wire logic                        pready_out,
    input wire logic                        pslverr_out,
    input wire logic [31:0]                 prdata_out,
    // pin side
    input wire port_pin_pkg::sleep_mode_t   sleep_mode_in,
    input wire port_pin_pkg::pin_override_t overrides_in,
    input wire logic [7:0]                  alt_function_input_tap_out,
    input wire logic [7:0]                  pad_in,
    input wire port_pin_pkg::pad_drive_t    pad_out
);
    // ********
    // shadow registers and expected pad controls
    // ********
    logic [7:0] dir_q, out_q, ien_q;
    logic       puoff_q, clamp;
    logic [7:0] pu_exp, de_exp, lvl_exp, gate_exp;

    // shadow follows only completed, accepted writes
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            dir_q   <= 8'h00;
            out_q   <= 8'h00;
            ien_q   <= 8'h00;
            puoff_q <= 1'b0;
        end else if (psel_in && penable_in && pwrite_in && pready_out && ce_in) begin
            if (paddr_in == `OFS_DIRECTION) dir_q <= pwdata_in[7:0];
            if (paddr_in == `OFS_OUT_VALUE) out_q <= pwdata_in[7:0];
            if (paddr_in == `OFS_INT_ENABLE) ien_q <= pwdata_in[7:0];
            if (paddr_in == `OFS_CONTROL) puoff_q <= pwdata_in[0];
        end
    end

    // override muxes per pin
    assign clamp    = sleep_mode_in inside {port_pin_pkg::MODE_ADC_QUIET,
                      port_pin_pkg::MODE_POWER_DOWN, port_pin_pkg::MODE_STANDBY};
    assign pu_exp   = (overrides_in.pullup_override_enable & overrides_in.pullup_override_value)
                    | (~overrides_in.pullup_override_enable & ~dir_q & out_q & {8{~puoff_q}});
    assign de_exp   = (overrides_in.direction_override_enable
                    & overrides_in.direction_override_value)
                    | (~overrides_in.direction_override_enable & dir_q);
    assign lvl_exp  = (overrides_in.out_level_override_enable
                    & overrides_in.out_level_override_value)
                    | (~overrides_in.out_level_override_enable & out_q);
    assign gate_exp = (overrides_in.input_gate_override_enable
                    & overrides_in.input_gate_override_value)
                    | (~overrides_in.input_gate_override_enable & ({8{~clamp}} | ien_q));

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence apb_setup;
        psel_in && !penable_in && ce_in;
    endsequence
    sequence apb_access;
        psel_in && penable_in && pready_out;
    endsequence

    pullup_mux_a: assert property (ce_in |=> pad_out.pullup_enable == $past(pu_exp))
        else $error("pull-up enable differs from mux");
    drive_enable_a: assert property (ce_in |=> pad_out.drive_enable == $past(de_exp))
        else $error("driver enable differs from mux");
    drive_level_a: assert property (ce_in |=>
        (pad_out.drive_level & pad_out.drive_enable) == $past(lvl_exp & de_exp))
        else $error("driven level differs from mux");
    input_gate_a: assert property (rst_n_in && ce_in |=>
        alt_function_input_tap_out == $past(pad_in & gate_exp))
        else $error("gated input tap wrong");
    reset_off_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
        !rst_n_in |-> pad_out.drive_enable == 8'h00 && pad_out.pullup_enable == 8'h00)
        else $error("pad active during reset");
    apb_answer_a: assert property (apb_setup |=> apb_access)
        else $error("setup not answered next cycle");
    ready_once_a: assert property (apb_access |=> !pready_out)
        else $error("ready held too long");
    idle_data_a: assert property (!pready_out |-> prdata_out == 32'h0 && !pslverr_out)
        else $error("read data or error outside access");
endmodule : port_pin_chk

bind port_pin_override_mux port_pin_chk port_pin_chk_inst (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .prdata_out(prdata_out), .sleep_mode_in(sleep_mode_in), .overrides_in(overrides_in),
    .alt_function_input_tap_out(alt_function_input_tap_out), .pad_in(pad_in),
    .pad_out(pad_out));

/* dv/port_pin_override_mux_test.sv */
// self-checking bench for the port pin override mux
`timescale 1ns/1ps
`include "port_pin_params.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end

module port_pin_override_mux_test;
    // ********
    // stimulus and wiring
    // ********
    logic                        clk = 1'b0, rst_n, psel = 1'b0, penable = 1'b0;
    logic                        pwrite = 1'b0, pready, pslverr;
    logic [11:0]                 paddr = 12'h000;
    logic [31:0]                 pwdata = 32'h0, prdata;
    logic [7:0]                  tap, pad_lvl, ext_lvl = 8'h00, ext_drv = 8'h00;
    port_pin_pkg::sleep_mode_t   mode = port_pin_pkg::MODE_ACTIVE;
    port_pin_pkg::pin_override_t af = '0, ovr;
    port_pin_pkg::pad_drive_t    pad;
    int                          n_fail = 0, checks = 0;

    always #2.5 clk = ~clk;

    port_pin_override_mux port_pin_override_mux_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
        .ce_in(1'b1), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .pready_out(pready), .pslverr_out(pslverr),
        .prdata_out(prdata), .sleep_mode_in(mode), .overrides_in(ovr),
        .alt_function_input_tap_out(tap), .pad_in(pad_lvl), .pad_out(pad));
    pad_world pad_world_inst (.clk_in(clk), .drive_in(pad), .overrides_out(ovr),
        .level_out(pad_lvl), .cfg_in(af), .ext_level_in(ext_lvl), .ext_drive_in(ext_drv));

    task automatic summarize;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // one apb transfer; waits on pready, never on a fixed count
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n >= 20) n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] ex,
                          input logic [31:0] m, input logic exe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        `CHK(nm, ex, r & m)
        `CHK("slverr", exe, e)
    endtask : rd_chk

    // register map, unmapped read refused
    task automatic t_regs;
        wr(`OFS_DIRECTION, 32'h000000CC);
        wr(`OFS_OUT_VALUE, 32'h000000AA);
        rd_chk("dir", `OFS_DIRECTION, 32'h000000CC, 32'hFFFFFFFF, 1'b0);
        rd_chk("outv", `OFS_OUT_VALUE, 32'h000000AA, 32'hFFFFFFFF, 1'b0);
        rd_chk("unmapped", 12'h040, 32'h0, 32'hFFFFFFFF, 1'b1);
    endtask : t_regs

    // pull-up from dir/out/global-off, then from the override pair
    task automatic t_pullup;
        repeat (2) @(posedge clk);
        `CHK("pullup", 8'h22, pad.pullup_enable)
        wr(`OFS_CONTROL, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("pullup off", 8'h00, pad.pullup_enable)
        af.pullup_override_enable <= 8'hF0;
        af.pullup_override_value <= 8'h30;
        wr(`OFS_CONTROL, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("pullup ovr", 8'h32, pad.pullup_enable)
        af <= '0;
    endtask : t_pullup

    // driver enable and level, half the pins' direction and two pins' level overridden
    task automatic t_drive;
        af.direction_override_enable <= 8'h0F;
        af.direction_override_value <= 8'h05;
        af.out_level_override_enable <= 8'h03;
        af.out_level_override_value <= 8'h01;
        repeat (3) @(posedge clk);
        `CHK("drv en", 8'hC5, pad.drive_enable)
        `CHK("drv lvl", 8'h81, pad.drive_level & pad.drive_enable)
        af <= '0;
        wr(`OFS_DIRECTION, 32'h0);
        wr(`OFS_OUT_VALUE, 32'h0);
    endtask : t_drive

    // input gating across every processor state, then gate override
    task automatic t_gate;
        logic [7:0] g;
        ext_drv <= 8'hFF;
        ext_lvl <= 8'h5A;
        wr(`OFS_INT_ENABLE, 32'h0F);
        for (int m = 0; m < 5; m++) begin
            mode <= port_pin_pkg::sleep_mode_t'(3'(m));
            repeat (6) @(posedge clk);
            g = (m >= 2) ? 8'h0F : 8'hFF;
            `CHK("tap", 8'h5A & g, tap)
            rd_chk("pin", `OFS_PIN_INPUT, {24'h0, 8'h5A & g}, 32'hFFFFFFFF, 1'b0);
        end
        af.input_gate_override_enable <= 8'hF0;
        af.input_gate_override_value <= 8'h30;
        repeat (6) @(posedge clk);
        `CHK("tap ovr", 8'h1A, tap)
        af <= '0;
        wr(`OFS_INT_ENABLE, 32'h0);
    endtask : t_gate

    // clamp release on a high pin gives a rising event
    task automatic t_wake;
        wr(`OFS_INT_SENSE, 32'h3);
        mode <= port_pin_pkg::MODE_ACTIVE;
        ext_lvl <= 8'h01;
        repeat (8) @(posedge clk);
        mode <= port_pin_pkg::MODE_POWER_DOWN;
        repeat (8) @(posedge clk);
        wr(`OFS_INT_FLAG, 32'h1);
        rd_chk("flag asleep", `OFS_INT_FLAG, 32'h0, 32'h1, 1'b0);
        mode <= port_pin_pkg::MODE_ACTIVE;
        repeat (8) @(posedge clk);
        rd_chk("flag wake", `OFS_INT_FLAG, 32'h1, 32'h1, 1'b0);
    endtask : t_wake

    // mid-run reset drops pull-ups and drivers without a clock edge
    task automatic t_reset;
        ext_drv <= 8'h00;
        wr(`OFS_OUT_VALUE, 32'hFF);
        repeat (2) @(posedge clk);
        `CHK("pullup set", 8'hFF, pad.pullup_enable)
        rst_n <= 1'b0;
        #1;
        `CHK("reset pads", 24'h0, pad)
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd_chk("outv rst", `OFS_OUT_VALUE, 32'h0, 32'hFFFFFFFF, 1'b0);
    endtask : t_reset

    // ********
    // main sequence and watchdog
    // ********
    initial begin
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK("reset pads", 24'h0, pad)
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_pullup();
        t_drive();
        t_gate();
        t_wake();
        t_reset();
        summarize();
    end

    // far beyond the hundred and fifty or so cycles needed
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule : port_pin_override_mux_test
